// [shared/sesr_pkg.sv]
// Purpose: constants for the sensor event and status register group
// Assumes: byte-wide register port, offsets as printed
// Notes: all offsets, field positions and mapped-register reset values live here
package sesr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] SESR_OFS_MEAS_STATUS = 8'h00;
  localparam logic [7:0] SESR_OFS_OUT_FIRST = 8'h01;
  localparam logic [7:0] SESR_OFS_OUT_LAST = 8'h05;
  localparam logic [7:0] SESR_OFS_QUEUE_STATUS = 8'h0d;
  localparam logic [7:0] SESR_OFS_FIFO_DELAY_TICKS = 8'h10;
  localparam logic [7:0] SESR_OFS_SYSTEM_MODE_STATE = 8'h11;
  localparam logic [7:0] SESR_OFS_EVENT_SOURCE_STATUS = 8'h12;
  localparam logic [7:0] SESR_OFS_DATA_EVENT_CONFIG = 8'h13;

  // ==========================================================
  // reset values, tick saturation limit and watermark off code
  localparam logic [7:0] SESR_RST_FIFO_DELAY_TICKS = 8'h00;
  localparam logic [7:0] SESR_RST_EVENT_SOURCE_STATUS = 8'h00;
  localparam logic [2:0] SESR_RST_DATA_EVENT_CONFIG = 3'h0;
  localparam logic SESR_RST_SYSTEM_MODE = 1'b0;
  localparam logic [7:0] SESR_RDATA_UNMAPPED = 8'h00;
  localparam logic [7:0] SESR_DELAY_TICK_MAX = 8'hff;
  localparam logic [5:0] SESR_WATERMARK_OFF = 6'h00;

  // ==========================================================
  // event source bit positions
  localparam int SESR_SRC_DATA_READY = 7;
  localparam int SESR_SRC_QUEUE = 6;
  localparam int SESR_SRC_P_WINDOW = 5;
  localparam int SESR_SRC_T_WINDOW = 4;
  localparam int SESR_SRC_P_THRESHOLD = 3;
  localparam int SESR_SRC_T_THRESHOLD = 2;
  localparam int SESR_SRC_P_CHANGE = 1;
  localparam int SESR_SRC_T_CHANGE = 0;
  localparam int SESR_NUM_SOURCES = 8;

  // ==========================================================
  // data event config fields
  localparam int SESR_CFG_READY_EVENT_MODE = 2;
  localparam int SESR_CFG_PRESSURE_EVENT_ENABLE = 1;
  localparam int SESR_CFG_TEMPERATURE_EVENT_ENABLE = 0;
  localparam int SESR_CFG_WIDTH = 3;

endpackage

// [shared/sesr_evt_if.sv]
// Purpose: carrier between register core and sticky status bits
// Assumes: single clock domain
// Notes: cond is the raw level, clr the one-cycle clear strobes
`timescale 1ns/10ps
`default_nettype none
interface sesr_evt_if;
  logic [7:0] cond;
  logic [7:0] clr;
  logic [7:0] status;

  modport core (output cond, output clr, input status);
  modport bits (input cond, input clr, output status);
endinterface
`default_nettype wire

// [verilog/sesr_edge_latch.sv]
// Purpose: rising-edge sticky status bits for the event sources
// Assumes: cond and clr come from logic on mclk_i
// Notes: a set in the clear cycle wins
`timescale 1ns/10ps
`default_nettype none
module sesr_edge_latch
  import sesr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // event carrier
  sesr_evt_if.bits evt
);

  logic [SESR_NUM_SOURCES-1:0] prev_reg;
  logic [SESR_NUM_SOURCES-1:0] prev_next;
  logic [SESR_NUM_SOURCES-1:0] status_reg;
  logic [SESR_NUM_SOURCES-1:0] status_next;

  // ==========================================================
  // per-source edge detect and hold
  genvar g;
  generate
    for (g = 0; g < SESR_NUM_SOURCES; g++) begin : g_src
      always_comb begin
        prev_next[g] = evt.cond[g];
        // a steady high level sets the bit only once
        if (evt.cond[g] && !prev_reg[g]) begin
          status_next[g] = 1'b1;
        end else if (evt.clr[g]) begin
          status_next[g] = 1'b0;
        end else begin
          status_next[g] = status_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= '0;
      status_reg <= SESR_RST_EVENT_SOURCE_STATUS;
    end else begin
      prev_reg <= prev_next;
      status_reg <= status_next;
    end
  end

  assign evt.status = status_reg;

endmodule // sesr_edge_latch
`default_nettype wire

// [verilog/sesr_regs.sv]
// Purpose: event source, system mode, delay tick and data event config registers
// Assumes: byte register port from the serial slave, all inputs on mclk_i
// Notes: read data are registered, one cycle after the read strobe
// Notes: bytes owned by other blocks read as zero here
`timescale 1ns/10ps
`default_nettype none
module sesr_regs
  import sesr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // system mode
  input wire logic mode_active_i,
  // measurement engine
  input wire logic acquisition_done_i,
  input wire logic pressure_changed_i,
  input wire logic temperature_changed_i,
  input wire logic data_ready_int_enable_i,
  // fifo events
  input wire logic queue_overflow_i,
  input wire logic queue_wrap_i,
  input wire logic queue_byte_written_i,
  input wire logic queue_last_byte_read_i,
  input wire logic sample_tick_i,
  // fifo levels
  input wire logic [5:0] queue_sample_count_i,
  input wire logic [5:0] queue_watermark_i,
  // alarm windows
  input wire logic pressure_window_nonzero_i,
  input wire logic temperature_window_nonzero_i,
  input wire logic pressure_near_target_i,
  input wire logic temperature_near_target_i,
  // alarm thresholds
  input wire logic pressure_cross_center_i,
  input wire logic pressure_cross_edge_i,
  input wire logic temperature_cross_center_i,
  input wire logic temperature_cross_edge_i,
  // alarm change detectors
  input wire logic pressure_delta_event_i,
  input wire logic temperature_delta_event_i,
  // status out
  output logic [7:0] event_source_status_o,
  output logic system_mode_state_o,
  // data flags and config
  output logic data_ready_flag_o,
  output logic data_overwrite_flag_o,
  output logic [2:0] data_event_config_o
);

  // ==========================================================
  // declarations
  sesr_evt_if evt ();

  logic [7:0] delay_tick_field_reg;
  logic [7:0] delay_tick_field_next;
  logic delay_run_reg;
  logic delay_run_next;
  logic delay_count_en;

  logic system_mode_state_reg;
  logic system_mode_state_next;

  logic [2:0] data_event_config_reg;
  logic [2:0] data_event_config_next;

  logic data_ready_flag_reg;
  logic data_ready_flag_next;
  logic data_overwrite_flag_reg;
  logic data_overwrite_flag_next;

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // read decode
  logic rd_meas;
  logic rd_status_byte;
  logic rd_out_bytes;
  logic rd_queue_status;
  logic rd_source;
  // event qualifiers
  logic new_event;
  logic p_event;
  logic t_event;
  logic watermark_hit;
  logic ready_event_mode;
  logic pressure_event_enable;
  logic temperature_event_enable;

  // ==========================================================
  // read decode
  always_comb begin
    rd_status_byte = reg_rd_i && (reg_addr_i == SESR_OFS_MEAS_STATUS);
    rd_out_bytes = reg_rd_i && (reg_addr_i >= SESR_OFS_OUT_FIRST) && (reg_addr_i <= SESR_OFS_OUT_LAST);
    // either read counts, so a host that skips status still clears
    rd_meas = rd_status_byte || rd_out_bytes;
    rd_queue_status = reg_rd_i && (reg_addr_i == SESR_OFS_QUEUE_STATUS);
    rd_source = reg_rd_i && (reg_addr_i == SESR_OFS_EVENT_SOURCE_STATUS);
  end

  // ==========================================================
  // data event config
  always_comb begin
    data_event_config_next = data_event_config_reg;
    // upper bits dropped on write
    // reserved bits are not stored, so reads show zero
    if (reg_wr_i && reg_addr_i == SESR_OFS_DATA_EVENT_CONFIG) begin
      data_event_config_next = reg_wdata_i[SESR_CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      data_event_config_reg <= SESR_RST_DATA_EVENT_CONFIG;
    end else begin
      data_event_config_reg <= data_event_config_next;
    end
  end

  assign ready_event_mode = data_event_config_reg[SESR_CFG_READY_EVENT_MODE];
  assign pressure_event_enable = data_event_config_reg[SESR_CFG_PRESSURE_EVENT_ENABLE];
  assign temperature_event_enable = data_event_config_reg[SESR_CFG_TEMPERATURE_EVENT_ENABLE];

  // ==========================================================
  // data ready and overwrite flags
  always_comb begin
    p_event = pressure_event_enable && (!ready_event_mode || pressure_changed_i);
    t_event = temperature_event_enable && (!ready_event_mode || temperature_changed_i);
    new_event = acquisition_done_i && (p_event || t_event);
  end

  // ==========================================================
  // flag update
  always_comb begin
    data_ready_flag_next = data_ready_flag_reg;
    data_overwrite_flag_next = data_overwrite_flag_reg;
    // new data wins over a clearing read in the same cycle
    if (new_event) begin
      data_ready_flag_next = 1'b1;
      if (data_ready_flag_reg && !rd_meas) begin
        data_overwrite_flag_next = 1'b1;
      end
    end else if (rd_meas) begin
      data_ready_flag_next = 1'b0;
      data_overwrite_flag_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ready_flag_reg <= 1'b0;
      data_overwrite_flag_reg <= 1'b0;
    end else begin
      data_ready_flag_reg <= data_ready_flag_next;
      data_overwrite_flag_reg <= data_overwrite_flag_next;
    end
  end

  // ==========================================================
  // event source conditions and clears
  always_comb begin
    // watermark zero means off, else an empty fifo would fire
    watermark_hit = (queue_watermark_i != SESR_WATERMARK_OFF) &&
                    (queue_sample_count_i == queue_watermark_i);
    evt.cond = '0;
    evt.cond[SESR_SRC_DATA_READY] = (data_overwrite_flag_reg || data_ready_flag_reg) &&
                                    data_ready_int_enable_i;
    evt.cond[SESR_SRC_QUEUE] = queue_overflow_i || watermark_hit;
    evt.cond[SESR_SRC_P_WINDOW] = pressure_window_nonzero_i && pressure_near_target_i;
    evt.cond[SESR_SRC_T_WINDOW] = temperature_window_nonzero_i && temperature_near_target_i;
    evt.cond[SESR_SRC_P_THRESHOLD] = pressure_cross_center_i ||
                                     (pressure_window_nonzero_i && pressure_cross_edge_i);
    evt.cond[SESR_SRC_T_THRESHOLD] = temperature_cross_center_i ||
                                     (temperature_window_nonzero_i && temperature_cross_edge_i);
    evt.cond[SESR_SRC_P_CHANGE] = pressure_delta_event_i;
    evt.cond[SESR_SRC_T_CHANGE] = temperature_delta_event_i;
  end

  // ==========================================================
  // read-clear strobes
  always_comb begin
    evt.clr = '0;
    evt.clr[SESR_SRC_DATA_READY] = rd_meas;
    evt.clr[SESR_SRC_QUEUE] = rd_queue_status;
    evt.clr[SESR_SRC_P_WINDOW] = rd_source;
    evt.clr[SESR_SRC_T_WINDOW] = rd_source;
    evt.clr[SESR_SRC_P_THRESHOLD] = rd_source;
    evt.clr[SESR_SRC_T_THRESHOLD] = rd_source;
    evt.clr[SESR_SRC_P_CHANGE] = rd_source;
    evt.clr[SESR_SRC_T_CHANGE] = rd_source;
  end

  // sticky bits kept apart so each source is one loop entry
  sesr_edge_latch sesr_edge_latch_i (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .evt(evt.bits)
  );

  // ==========================================================
  // fifo delay tick counter
  always_comb begin
    // the starting cycle counts too, so a tick on overflow is not lost
    delay_count_en = (delay_run_reg || queue_overflow_i || queue_wrap_i) && sample_tick_i;
    delay_tick_field_next = delay_tick_field_reg;
    delay_run_next = delay_run_reg;
    if (queue_last_byte_read_i) begin
      delay_tick_field_next = SESR_RST_FIFO_DELAY_TICKS;
      delay_run_next = 1'b0;
    end else begin
      if (queue_overflow_i || queue_wrap_i) begin
        delay_run_next = 1'b1;
      end
      if (queue_byte_written_i) begin
        delay_tick_field_next = SESR_RST_FIFO_DELAY_TICKS;
      end else if (delay_count_en && delay_tick_field_reg != SESR_DELAY_TICK_MAX) begin
        // saturate rather than wrap so a long idle never looks fresh
        delay_tick_field_next = delay_tick_field_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_tick_field_reg <= SESR_RST_FIFO_DELAY_TICKS;
      delay_run_reg <= 1'b0;
    end else begin
      delay_tick_field_reg <= delay_tick_field_next;
      delay_run_reg <= delay_run_next;
    end
  end

  // ==========================================================
  // system mode
  always_comb begin
    // one-cycle lag, the mode source sits on the same clock
    system_mode_state_next = mode_active_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      system_mode_state_reg <= SESR_RST_SYSTEM_MODE;
    end else begin
      system_mode_state_reg <= system_mode_state_next;
    end
  end

  // ==========================================================
  // read mux, registered
  always_comb begin
    // hold the last byte until the next read strobe
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        SESR_OFS_FIFO_DELAY_TICKS: rdata_next = delay_tick_field_reg;
        SESR_OFS_SYSTEM_MODE_STATE: rdata_next = {7'h00, system_mode_state_reg};
        SESR_OFS_EVENT_SOURCE_STATUS: rdata_next = evt.status;
        SESR_OFS_DATA_EVENT_CONFIG: rdata_next = {5'h00, data_event_config_reg};
        default: rdata_next = SESR_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= SESR_RDATA_UNMAPPED;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o = rdata_reg;
  assign event_source_status_o = evt.status;
  assign system_mode_state_o = system_mode_state_reg;
  assign data_ready_flag_o = data_ready_flag_reg;
  assign data_overwrite_flag_o = data_overwrite_flag_reg;
  assign data_event_config_o = data_event_config_reg;

endmodule // sesr_regs
`default_nettype wire

// [verif/sesr_regs_checker.sv]
// Purpose: port-level checks of sesr_regs
// Assumes: one clock, rst_i async high
// Notes: bound to every sesr_regs instance
`timescale 1ns/10ps
`default_nettype none
module sesr_regs_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // sources
  input wire logic mode_active_i,
  input wire logic acquisition_done_i,
  input wire logic data_ready_int_enable_i,
  input wire logic queue_overflow_i,
  input wire logic pressure_window_nonzero_i,
  input wire logic pressure_delta_event_i,
  // status
  input wire logic [7:0] event_source_status_o,
  input wire logic system_mode_state_o,
  input wire logic data_ready_flag_o,
  input wire logic data_overwrite_flag_o,
  input wire logic [2:0] data_event_config_o
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire drdy_c = (data_ready_flag_o | data_overwrite_flag_o) & data_ready_int_enable_i;

  a_mode_lag: assert property (system_mode_state_o == $past(mode_active_i))
    else $error("mode bit does not follow mode input");
  a_mode_read: assert property (reg_rd_i && reg_addr_i == 8'h11 |=>
    reg_rdata_o == {7'h00, $past(system_mode_state_o)}) else $error("mode read wrong");
  a_status_read: assert property (reg_rd_i && reg_addr_i == 8'h12 |=>
    reg_rdata_o == $past(event_source_status_o)) else $error("status read wrong");
  a_delta_clear: assert property (reg_rd_i && reg_addr_i == 8'h12 && !pressure_delta_event_i
    |=> !event_source_status_o[1]) else $error("change bit not cleared");
  a_delta_set: assert property ($rose(pressure_delta_event_i) |=> event_source_status_o[1])
    else $error("change bit not set");
  a_delta_edge: assert property ($rose(event_source_status_o[1]) |->
    $past(pressure_delta_event_i) && !$past(pressure_delta_event_i, 2)) else $error("set without edge");
  a_window_gate: assert property ($rose(event_source_status_o[5]) |-> $past(pressure_window_nonzero_i))
    else $error("window bit with zero window");
  a_queue_set: assert property ($rose(queue_overflow_i) |=> event_source_status_o[6])
    else $error("queue bit not set");
  a_cfg_write: assert property (reg_wr_i && reg_addr_i == 8'h13 |=>
    data_event_config_o == $past(reg_wdata_i[2:0])) else $error("config write lost");
  a_ready_set: assert property ($rose(drdy_c) |=> event_source_status_o[7])
    else $error("ready bit not set");
  a_ready_clear: assert property (reg_rd_i && reg_addr_i <= 8'h05 && !acquisition_done_i
    |=> !data_ready_flag_o && !data_overwrite_flag_o) else $error("data flags not cleared");

  c_ready: cover property ($rose(event_source_status_o[7]));
  c_queue: cover property ($rose(event_source_status_o[6]));
  c_ticks: cover property (reg_rd_i && reg_addr_i == 8'h10 ##1 reg_rdata_o != 8'h00);
endmodule // sesr_regs_checker

bind sesr_regs sesr_regs_checker sesr_regs_checker_i (.*);
`default_nettype wire

// [verif/sesr_host.sv]
// Purpose: host side of the byte register port
// Assumes: strobes launched 1 ns after the rising edge
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module sesr_host (
  // clock and read data
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  // strobes
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // reads of status and output bytes are what clear sticky bits
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1 addr_o = a;
    rd_o = 1'b1;
    @(posedge mclk_i);
    #1 rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    #1 addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(posedge mclk_i);
    #1 wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
  endtask
endmodule // sesr_host
`default_nettype wire

// [verif/tb_sesr_regs.sv]
// Purpose: self-checking bench for sesr_regs
// Assumes: 125 MHz clock, inputs driven 1 ns after the edge
// Notes: pu bits are acq, overflow, wrap, byte written, last read, tick
`timescale 1ns/10ps
`default_nettype none
module tb_sesr_regs;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, st;
  logic rd, wr, sm, rdy, ow;
  logic mode = 1'b0, drie = 1'b0, pchg = 1'b0, tchg = 1'b0;
  logic [5:0] pu = 6'h00, cnt = 6'h00, wm = 6'h00;
  logic [9:0] al = 10'h000;
  logic [2:0] cfg;
  int failures = 0, checks = 0, cyc = 0;

  always #4 mclk_i = ~mclk_i;

  sesr_host sesr_host_i (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata));
  sesr_regs sesr_regs_i (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mode_active_i(mode),
    .acquisition_done_i(pu[0]), .pressure_changed_i(pchg), .temperature_changed_i(tchg),
    .data_ready_int_enable_i(drie), .queue_overflow_i(pu[1]), .queue_wrap_i(pu[2]),
    .queue_byte_written_i(pu[3]), .queue_last_byte_read_i(pu[4]), .sample_tick_i(pu[5]),
    .queue_sample_count_i(cnt), .queue_watermark_i(wm), .pressure_window_nonzero_i(al[0]),
    .temperature_window_nonzero_i(al[1]), .pressure_near_target_i(al[2]),
    .temperature_near_target_i(al[3]), .pressure_cross_center_i(al[4]), .pressure_cross_edge_i(al[5]),
    .temperature_cross_center_i(al[6]), .temperature_cross_edge_i(al[7]),
    .pressure_delta_event_i(al[8]), .temperature_delta_event_i(al[9]), .event_source_status_o(st),
    .system_mode_state_o(sm), .data_ready_flag_o(rdy), .data_overwrite_flag_o(ow),
    .data_event_config_o(cfg));

  // ==========================================================
  // helpers
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    sesr_host_i.rd(a, d);
    chk(d, e);
  endtask
  task automatic pl(input logic [5:0] v);
    @(posedge mclk_i);
    #1 pu = v;
    @(posedge mclk_i);
    #1 pu = 6'h00;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h00);
    rdc(8'h12, 8'h00);
    rdc(8'h13, 8'h00);
    rdc(8'h20, 8'h00);
  endtask
  task automatic t_mode;
    mode = 1'b1;
    rdc(8'h11, 8'h01);
    mode = 1'b0;
    rdc(8'h11, 8'h00);
  endtask
  task automatic t_cfg;
    sesr_host_i.wr(8'h13, 8'hff);
    rdc(8'h13, 8'h07);
    chk({5'h00, cfg}, 8'h07);
    sesr_host_i.wr(8'h12, 8'hff);
    rdc(8'h12, 8'h00);
    sesr_host_i.wr(8'h13, 8'h00);
    rdc(8'h13, 8'h00);
  endtask
  task automatic t_fifo;
    pl(6'h02);
    chk(st, 8'h40);
    rdc(8'h12, 8'h40);
    rdc(8'h12, 8'h40);
    rdc(8'h0d, 8'h00);
    rdc(8'h12, 8'h00);
    cnt = 6'h02;
    wm = 6'h03;
    rdc(8'h12, 8'h00);
    cnt = 6'h03;
    rdc(8'h12, 8'h40);
    rdc(8'h0d, 8'h00);
    cnt = 6'h00;
    wm = 6'h00;
    rdc(8'h12, 8'h00);
  endtask
  task automatic t_src;
    logic [9:0] v [12] = '{10'h004, 10'h005, 10'h00a, 10'h009, 10'h010, 10'h020, 10'h021, 10'h040,
      10'h080, 10'h082, 10'h100, 10'h200};
    logic [7:0] e [12] = '{8'h00, 8'h20, 8'h10, 8'h00, 8'h08, 8'h00, 8'h08, 8'h04, 8'h00, 8'h04,
      8'h02, 8'h01};
    for (int i = 0; i < 12; i++) begin
      al = v[i];
      pl(6'h00);
      al = 10'h000;
      rdc(8'h12, e[i]);
    end
    al = 10'h100;
    rdc(8'h12, 8'h02);
    rdc(8'h12, 8'h00);
    al = 10'h000;
  endtask
  task automatic t_drdy;
    sesr_host_i.wr(8'h13, 8'h02);
    pl(6'h01);
    rdc(8'h12, 8'h00);
    drie = 1'b1;
    rdc(8'h12, 8'h80);
    chk({7'h00, rdy}, 8'h01);
    pl(6'h01);
    chk({7'h00, ow}, 8'h01);
    rdc(8'h00, 8'h00);
    rdc(8'h12, 8'h00);
    sesr_host_i.wr(8'h13, 8'h06);
    pl(6'h01);
    rdc(8'h12, 8'h00);
    pchg = 1'b1;
    pl(6'h01);
    pchg = 1'b0;
    rdc(8'h12, 8'h80);
    rdc(8'h05, 8'h00);
    sesr_host_i.wr(8'h13, 8'h01);
    pl(6'h01);
    rdc(8'h12, 8'h80);
    rdc(8'h03, 8'h00);
    sesr_host_i.wr(8'h13, 8'h05);
    pl(6'h01);
    rdc(8'h12, 8'h00);
    tchg = 1'b1;
    pl(6'h01);
    tchg = 1'b0;
    rdc(8'h12, 8'h80);
    rdc(8'h01, 8'h00);
  endtask
  task automatic t_ticks;
    // the overflow pulse of the fifo scenario left the counter running
    pl(6'h10);
    rdc(8'h10, 8'h00);
    pl(6'h20);
    rdc(8'h10, 8'h00);
    pl(6'h04);
    repeat (3) pl(6'h20);
    rdc(8'h10, 8'h03);
    pl(6'h08);
    pl(6'h20);
    rdc(8'h10, 8'h01);
    pl(6'h10);
    pl(6'h20);
    rdc(8'h10, 8'h00);
  endtask

  // ==========================================================
  // run and watchdog, well above the under two hundred cycles needed
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    t_reset;
    t_mode;
    t_cfg;
    t_fifo;
    t_src;
    t_drdy;
    t_ticks;
    conclude;
  end
endmodule // tb_sesr_regs
`default_nettype wire
